// ### pkg/ppm_pkg.sv
package ppm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int unsigned AXI_ADDR_W = 12;
  localparam int unsigned AXI_DATA_W = 32;
  localparam int unsigned AXI_STRB_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices as printed; the byte address is four times the index
  localparam logic [7:0] IDX_CAPS  = 8'h46;
  localparam logic [7:0] IDX_CSR   = 8'h48;
  localparam logic [7:0] IDX_BSE   = 8'h4a;
  localparam logic [7:0] IDX_DATA  = 8'h4b;
  localparam logic [7:0] IDX_EVENT = 8'h50;
  localparam logic [7:0] IDX_MASK  = 8'h51;

  localparam logic [AXI_ADDR_W-1:0] ADDR_CAPS  = {2'h0, IDX_CAPS, 2'h0};
  localparam logic [AXI_ADDR_W-1:0] ADDR_CSR   = {2'h0, IDX_CSR, 2'h0};
  localparam logic [AXI_ADDR_W-1:0] ADDR_BSE   = {2'h0, IDX_BSE, 2'h0};
  localparam logic [AXI_ADDR_W-1:0] ADDR_DATA  = {2'h0, IDX_DATA, 2'h0};
  localparam logic [AXI_ADDR_W-1:0] ADDR_EVENT = {2'h0, IDX_EVENT, 2'h0};
  localparam logic [AXI_ADDR_W-1:0] ADDR_MASK  = {2'h0, IDX_MASK, 2'h0};

  ////////////////////////////////////////////////////////////////////////////
  // Control/status field layout
  localparam int unsigned CSR_FLAG_BIT   = 15;
  localparam int unsigned CSR_SCALE_LSB  = 13;
  localparam int unsigned CSR_INDEX_LSB  = 9;
  localparam int unsigned CSR_ENABLE_BIT = 8;
  localparam int unsigned CSR_STATE_LSB  = 0;
  localparam logic [15:0] CSR_RESET      = 16'h0000;

  // Capabilities: fixed bits, cold-wake bit and aux-current field position
  localparam logic [15:0] CAPS_FIXED   = 16'h7e02;
  localparam int unsigned CAPS_COLD_BIT = 15;
  localparam int unsigned CAPS_AUX_LSB  = 6;

  localparam logic [7:0] BSE_VALUE   = 8'h00;
  localparam logic [7:0] DATA_RESET  = 8'h00;
  localparam logic [1:0] SCALE_RESET = 2'h0;
  localparam int unsigned DATA_LOADABLE = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Power states
  localparam logic [1:0] PWR_D0 = 2'h0;
  localparam logic [1:0] PWR_D3 = 2'h3;

  // Interrupt event bits
  localparam int unsigned EVT_WAKE  = 0;
  localparam int unsigned EVT_STATE = 1;
  localparam int unsigned EVT_W     = 2;
  localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ppm_pkg

// ### verilog/ppm_power_ctrl.sv
`timescale 1ns/1ps
// How it works
// [R1] Internal D3hot-to-D0 reset leaves control/status alone
// [R2] Cold-wake capable: wake bits survive PCI reset
// [R3] Not capable: PCI reset zeroes whole register
// [R4] Wake event sets flag regardless of enable
// [R5] Writing one clears flag and PME
// [R6] Enable bit gates PME; clear means none
// [R7] Four-bit index selects reported power entry
// [R8] Scale field gives multiplier of selected value
// [R9] Dynamic-data and reserved bits read zero
// [R10] Two-bit power state field, D0 to D3
// [R11] Bridge-support byte always reads zero
// [R12] Sixteen entries, default zero, eight loadable
// [R13] Indices eight to fifteen read zero
// [R14] Image builder keeps data and aux exclusive
// [R15] Capability bit fifteen reports cold wake
// [R16] PME driven while flag and enable set
module ppm_power_ctrl (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        por_rst_in,
  input  wire logic        wake_from_cold_capable_in,
  input  wire logic [2:0]  aux_current_field_in,
  input  wire logic        wake_event_in,
  input  wire logic        load_valid_in,
  input  wire logic [2:0]  load_index_in,
  input  wire logic [7:0]  load_value_in,
  input  wire logic [1:0]  load_scale_in,
  input  wire logic [11:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [11:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic             pme_out,
  output logic             irq_out,
  output logic [1:0]       device_power_state_out,
  output logic             d3hot_exit_rst_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic        aw_held, next_aw_held;
  logic [11:0] aw_addr, next_aw_addr;
  logic        w_held, next_w_held;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        bvalid, next_bvalid;
  logic [1:0]  bresp, next_bresp;
  logic        rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0]  rresp, next_rresp;
  logic [1:0]  power_state, next_power_state;
  logic [3:0]  value_index, next_value_index;
  logic        exit_pulse, next_exit_pulse;
  logic        wake_event_flag, next_wake_event_flag;
  logic        wake_event_enable, next_wake_event_enable;
  logic [7:0]  value_table [ppm_pkg::DATA_LOADABLE], next_value_table [ppm_pkg::DATA_LOADABLE];
  logic [1:0]  scale_table [ppm_pkg::DATA_LOADABLE], next_scale_table [ppm_pkg::DATA_LOADABLE];
  logic [ppm_pkg::EVT_W-1:0] event_status, next_event_status;
  logic [ppm_pkg::EVT_W-1:0] event_mask, next_event_mask;

  logic        do_write;
  logic        wr_csr;
  logic        wr_event;
  logic        wr_mask;
  logic        wr_mapped;
  logic        rd_mapped;
  logic [7:0]  power_value_byte;
  logic [1:0]  selected_scale;
  logic [15:0] csr_word;
  logic [15:0] caps_word;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and read views
  assign do_write  = aw_held && w_held && !bvalid;
  assign wr_csr    = do_write && (aw_addr[11:2] == ppm_pkg::ADDR_CSR[11:2]);
  assign wr_event  = do_write && (aw_addr[11:2] == ppm_pkg::ADDR_EVENT[11:2]);
  assign wr_mask   = do_write && (aw_addr[11:2] == ppm_pkg::ADDR_MASK[11:2]);
  assign wr_mapped = (aw_addr[11:2] == ppm_pkg::ADDR_CAPS[11:2]) || (aw_addr[11:2] == ppm_pkg::ADDR_CSR[11:2])
                  || (aw_addr[11:2] == ppm_pkg::ADDR_BSE[11:2]) || (aw_addr[11:2] == ppm_pkg::ADDR_DATA[11:2])
                  || (aw_addr[11:2] == ppm_pkg::ADDR_EVENT[11:2]) || (aw_addr[11:2] == ppm_pkg::ADDR_MASK[11:2]);

  // Upper half of the table is never loaded and always reads zero
  always_comb begin
    if (value_index[3]) begin
      power_value_byte = ppm_pkg::DATA_RESET;                           // see [R13]
      selected_scale   = ppm_pkg::SCALE_RESET;
    end else begin
      power_value_byte = value_table[value_index[2:0]];                 // see [R7]
      selected_scale   = scale_table[value_index[2:0]];                 // see [R8]
    end
  end

  always_comb begin
    csr_word = 16'h0000;                                                // see [R9]
    csr_word[ppm_pkg::CSR_FLAG_BIT] = wake_event_flag;
    csr_word[ppm_pkg::CSR_SCALE_LSB +: 2] = selected_scale;             // see [R8]
    csr_word[ppm_pkg::CSR_INDEX_LSB +: 4] = value_index;
    csr_word[ppm_pkg::CSR_ENABLE_BIT] = wake_event_enable;
    csr_word[ppm_pkg::CSR_STATE_LSB +: 2] = power_state;                // see [R10]
  end

  always_comb begin
    caps_word = ppm_pkg::CAPS_FIXED;
    caps_word[ppm_pkg::CAPS_COLD_BIT] = wake_from_cold_capable_in;      // see [R15]
    caps_word[ppm_pkg::CAPS_AUX_LSB +: 3] = aux_current_field_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  assign s_axi_awready_out = !aw_held && !bvalid;
  assign s_axi_wready_out  = !w_held && !bvalid;
  assign s_axi_arready_out = !rvalid;
  assign s_axi_bvalid_out  = bvalid;
  assign s_axi_bresp_out   = bresp;
  assign s_axi_rvalid_out  = rvalid;
  assign s_axi_rdata_out   = rdata;
  assign s_axi_rresp_out   = rresp;

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    rd_mapped    = 1'b1;
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_in;
      next_w_strb = s_axi_wstrb_in;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_mapped ? ppm_pkg::RESP_OKAY : ppm_pkg::RESP_SLVERR;
    end else if (bvalid && s_axi_bready_in) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      next_rvalid = 1'b1;
      next_rdata  = 32'h0000_0000;
      case (s_axi_araddr_in[11:2])
        ppm_pkg::ADDR_CAPS[11:2]:  next_rdata[15:0] = caps_word;
        ppm_pkg::ADDR_CSR[11:2]:   next_rdata[15:0] = csr_word;
        ppm_pkg::ADDR_BSE[11:2]:   next_rdata[7:0]  = ppm_pkg::BSE_VALUE;         // see [R11]
        ppm_pkg::ADDR_DATA[11:2]:  next_rdata[7:0]  = power_value_byte;          // see [R7]
        ppm_pkg::ADDR_EVENT[11:2]: next_rdata[ppm_pkg::EVT_W-1:0] = event_status;
        ppm_pkg::ADDR_MASK[11:2]:  next_rdata[ppm_pkg::EVT_W-1:0] = event_mask;
        default:                   rd_mapped = 1'b0;
      endcase
      next_rresp = rd_mapped ? ppm_pkg::RESP_OKAY : ppm_pkg::RESP_SLVERR;
    end else if (rvalid && s_axi_rready_in) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= ppm_pkg::RESP_OKAY;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= ppm_pkg::RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held  <= next_w_held;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state and index; only PCI reset touches them
  always_comb begin
    next_power_state = power_state;
    next_value_index = value_index;
    next_exit_pulse  = 1'b0;
    if (wr_csr && w_strb[0]) begin
      next_power_state = w_data[ppm_pkg::CSR_STATE_LSB +: 2];          // see [R10]
      // Going from D3hot to D0 resets the function, not this register
      next_exit_pulse  = (power_state == ppm_pkg::PWR_D3) && (next_power_state == ppm_pkg::PWR_D0);  // see [R1]
    end
    if (wr_csr && w_strb[1]) begin
      next_value_index = w_data[ppm_pkg::CSR_INDEX_LSB +: 4];          // see [R7]
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      power_state <= ppm_pkg::CSR_RESET[ppm_pkg::CSR_STATE_LSB +: 2]; // see [R3]
      value_index <= ppm_pkg::CSR_RESET[ppm_pkg::CSR_INDEX_LSB +: 4];
      exit_pulse  <= 1'b0;
    end else begin
      power_state <= next_power_state;
      value_index <= next_value_index;
      exit_pulse  <= next_exit_pulse;
    end
  end

  assign device_power_state_out = power_state;
  assign d3hot_exit_rst_out     = exit_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // Wake bits: power-on reset clears them; PCI reset clears them only when
  // cold wake is not supported, done synchronously since the strap is a port
  always_comb begin
    next_wake_event_flag   = wake_event_flag;
    next_wake_event_enable = wake_event_enable;
    if (wr_csr && w_strb[1]) begin
      next_wake_event_enable = w_data[ppm_pkg::CSR_ENABLE_BIT];
      if (w_data[ppm_pkg::CSR_FLAG_BIT]) begin
        next_wake_event_flag = 1'b0;                                    // see [R5]
      end
    end
    if (wake_event_in) begin
      next_wake_event_flag = 1'b1;                                      // see [R4]
    end
    if (sys_rst_in) begin
      if (wake_from_cold_capable_in) begin
        next_wake_event_flag   = wake_event_flag | wake_event_in;       // see [R2]
        next_wake_event_enable = wake_event_enable;                     // see [R2]
      end else begin
        next_wake_event_flag   = ppm_pkg::CSR_RESET[ppm_pkg::CSR_FLAG_BIT];    // see [R3]
        next_wake_event_enable = ppm_pkg::CSR_RESET[ppm_pkg::CSR_ENABLE_BIT];  // see [R3]
      end
    end
  end

  always_ff @(posedge clk_in or posedge por_rst_in) begin
    if (por_rst_in) begin
      wake_event_flag   <= 1'b0;
      wake_event_enable <= 1'b0;
    end else begin
      wake_event_flag   <= next_wake_event_flag;
      wake_event_enable <= next_wake_event_enable;
    end
  end

  assign pme_out = wake_event_flag && wake_event_enable;               // see [R6] see [R16]

  ////////////////////////////////////////////////////////////////////////////
  // Power data table, loaded by the configuration memory reader
  always_comb begin
    for (int i = 0; i < ppm_pkg::DATA_LOADABLE; i++) begin
      next_value_table[i] = value_table[i];
      next_scale_table[i] = scale_table[i];
    end
    if (load_valid_in) begin
      next_value_table[load_index_in] = load_value_in;                  // see [R12]
      next_scale_table[load_index_in] = load_scale_in;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < ppm_pkg::DATA_LOADABLE; i++) begin
        value_table[i] <= ppm_pkg::DATA_RESET;                          // see [R12]
        scale_table[i] <= ppm_pkg::SCALE_RESET;
      end
    end else begin
      for (int i = 0; i < ppm_pkg::DATA_LOADABLE; i++) begin
        value_table[i] <= next_value_table[i];
        scale_table[i] <= next_scale_table[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask; a new event wins over a same-cycle clear
  always_comb begin
    next_event_status = event_status;
    next_event_mask   = event_mask;
    if (wr_event && w_strb[0]) begin
      next_event_status = event_status & ~w_data[ppm_pkg::EVT_W-1:0];
    end
    if (wr_mask && w_strb[0]) begin
      next_event_mask = w_data[ppm_pkg::EVT_W-1:0];
    end
    if (wake_event_in) begin
      next_event_status[ppm_pkg::EVT_WAKE] = 1'b1;
    end
    if (next_power_state != power_state) begin
      next_event_status[ppm_pkg::EVT_STATE] = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      event_status <= ppm_pkg::EVT_RESET;
      event_mask   <= ppm_pkg::EVT_RESET;
    end else begin
      event_status <= next_event_status;
      event_mask   <= next_event_mask;
    end
  end

  assign irq_out = |(event_status & event_mask);

endmodule : ppm_power_ctrl

// ### dv/ppm_cfg_loader.sv
`timescale 1ns/1ps
module ppm_cfg_loader (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        go_in,
  input  wire logic [63:0] vals_in,
  input  wire logic [15:0] scales_in,
  output logic             load_valid_out,
  output logic [2:0]       load_index_out,
  output logic [7:0]       load_value_out,
  output logic [1:0]       load_scale_out,
  output logic [2:0]       aux_current_field_out
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (go_in) begin
      next_cnt = 4'h0;
    end else if (cnt < 4'h8) begin
      next_cnt = cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= 4'h8;
    end else begin
      cnt <= next_cnt;
    end
  end

  // Walks the first eight entries once per start
  assign load_valid_out = cnt < 4'h8;
  assign load_index_out = cnt[2:0];
  assign load_value_out = load_valid_out ? vals_in[cnt[2:0]*8 +: 8] : ~vals_in[7:0];
  assign load_scale_out = load_valid_out ? scales_in[cnt[2:0]*2 +: 2] : ~scales_in[1:0];
  // Image carries aux current only when no power data is present
  assign aux_current_field_out = (|vals_in) ? 3'h0 : 3'h5;
endmodule : ppm_cfg_loader

// ### dv/ppm_power_ctrl_monitor.sv
`timescale 1ns/1ps
module ppm_power_ctrl_monitor (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        por_rst_in,
  input wire logic        wake_event_in,
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0]  s_axi_rresp_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        pme_out,
  input wire logic        irq_out,
  input wire logic [1:0]  device_power_state_out,
  input wire logic        d3hot_exit_rst_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in || por_rst_in);

  chk_pme_rise: assert property ($rose(pme_out) |-> $past(wake_event_in) || s_axi_bvalid_out)
    else $error("pme rose without event or write");
  chk_pme_fall: assert property ($fell(pme_out) |-> s_axi_bvalid_out)
    else $error("pme fell without write");
  chk_irq_rise: assert property ($rose(irq_out) |-> $past(wake_event_in) || s_axi_bvalid_out)
    else $error("irq rose without cause");
  chk_state_hold: assert property (!s_axi_bvalid_out |-> $stable(device_power_state_out))
    else $error("power state moved without write");
  chk_exit_once: assert property (d3hot_exit_rst_out |=> !d3hot_exit_rst_out)
    else $error("exit pulse longer than one cycle");
  chk_exit_cause: assert property ($rose(d3hot_exit_rst_out) |-> s_axi_bvalid_out &&
    device_power_state_out == ppm_pkg::PWR_D0)
    else $error("exit pulse without write of D0");
  chk_bse_zero: assert property (s_axi_arvalid_in && s_axi_arready_out &&
    s_axi_araddr_in == ppm_pkg::ADDR_BSE |=> s_axi_rdata_out == 32'h0 && s_axi_rresp_out == ppm_pkg::RESP_OKAY)
    else $error("bridge byte not zero");
  chk_rd_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  chk_rd_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out &&
    $stable(s_axi_rdata_out))
    else $error("read data dropped");
  chk_wr_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out &&
    $stable(s_axi_bresp_out))
    else $error("write response dropped");
  chk_ar_block: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read taken while answer pending");
  chk_wr_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
    |-> ##[1:2] s_axi_bvalid_out)
    else $error("write answer late");

  cov_pme: cover property ($rose(pme_out));
  cov_irq: cover property ($rose(irq_out));
  cov_exit: cover property ($rose(d3hot_exit_rst_out));
endmodule : ppm_power_ctrl_monitor

bind ppm_power_ctrl ppm_power_ctrl_monitor mon_u (.*);

// ### dv/ppm_power_ctrl_tb.sv
`timescale 1ns/1ps
module ppm_power_ctrl_tb;
  localparam logic [11:0] CSR = ppm_pkg::ADDR_CSR;
  localparam logic [11:0] DAT = ppm_pkg::ADDR_DATA;
  localparam logic [11:0] EVT = ppm_pkg::ADDR_EVENT;
  localparam logic [11:0] MSK = ppm_pkg::ADDR_MASK;
  localparam logic [11:0] BSE = ppm_pkg::ADDR_BSE;
  localparam logic [1:0]  ERR = ppm_pkg::RESP_SLVERR;
  logic        clk_in = 1'b0;
  logic        srst = 1'b1;
  logic        por = 1'b1;
  logic        cold = 1'b0;
  logic        wake = 1'b0;
  logic        go = 1'b0;
  logic [63:0] vals = 64'h0;
  logic [15:0] scs = 16'h0;
  logic [15:0] lf = 16'h1737;
  logic [11:0] awaddr = 12'h0;
  logic [11:0] araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, pme, irq, ld_v, xrst;
  logic [1:0]  bresp, rresp, ld_s, pst;
  logic [31:0] rdata;
  logic [2:0]  ld_i, aux;
  logic [7:0]  ld_d;
  logic [33:0] exp_q[$];
  int          miscompares = 0;
  int          n_compared = 0;
  int          n_exit = 0;

  always #25 clk_in = ~clk_in;

  ppm_cfg_loader ldr_u (.clk_in(clk_in), .rst_in(por), .go_in(go), .vals_in(vals), .scales_in(scs),
    .load_valid_out(ld_v), .load_index_out(ld_i), .load_value_out(ld_d), .load_scale_out(ld_s),
    .aux_current_field_out(aux));

  ppm_power_ctrl dut_u (.clk_in(clk_in), .sys_rst_in(srst), .por_rst_in(por),
    .wake_from_cold_capable_in(cold), .aux_current_field_in(aux), .wake_event_in(wake),
    .load_valid_in(ld_v), .load_index_in(ld_i), .load_value_in(ld_d), .load_scale_in(ld_s),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .pme_out(pme), .irq_out(irq), .device_power_state_out(pst), .d3hot_exit_rst_out(xrst));

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next

  function automatic logic [33:0] csr(input logic f, input logic [1:0] sc, input logic [3:0] ix,
                                      input logic e, input logic [1:0] st);
    return {2'h0, 16'h0, f, sc, ix, e, 6'h0, st};
  endfunction : csr

  task automatic check(input logic [33:0] s, input logic [33:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task automatic bus(input bit w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [33:0] e);
    int n;
    bit ta, tw, tr, td;
    n = 0;
    td = 1'b0;
    exp_q.push_back(e);
    @(posedge clk_in);
    awaddr  <= a;
    araddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= w;
    wvalid  <= w;
    arvalid <= !w;
    while (!td && n < 40) begin
      @(negedge clk_in);
      n++;
      ta = awready;
      tw = wready;
      tr = arready;
      td = w ? (bvalid && bready) : (rvalid && rready);
      @(posedge clk_in);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tr) arvalid <= 1'b0;
      bready <= w && !td && n > 1;
      rready <= !w && !td && n > 1;
    end
    if (!td) miscompares++;
  endtask : bus

  task automatic pulse_wake();
    wake <= 1'b1;
    @(posedge clk_in);
    wake <= 1'b0;
  endtask : pulse_wake

  task automatic pci_rst();
    srst <= 1'b1;
    repeat (3) @(posedge clk_in);
    srst <= 1'b0;
  endtask : pci_rst

  // Response watcher: every answer is matched against the oldest note
  always @(negedge clk_in) begin
    if (bvalid && bready) check({bresp, 32'h0}, exp_q.pop_front());
    if (rvalid && rready) check({rresp, rdata}, exp_q.pop_front());
    if (xrst) n_exit++;
  end

  initial begin
    #500000;
    miscompares++;
    print_verdict();
  end

  initial begin
    int i;
    for (i = 0; i < 8; i++) begin
      lf = lfsr_next(lf);
      vals[i*8 +: 8] = lf[7:0];
      scs[i*2 +: 2] = lf[9:8];
    end
    repeat (8) @(posedge clk_in);
    srst <= 1'b0;
    por <= 1'b0;
    bus(0, CSR, 0, 0, csr(0, 0, 0, 0, 0));
    bus(0, BSE, 0, 0, 34'h0);
    bus(0, DAT, 0, 0, 34'h0);
    bus(0, ppm_pkg::ADDR_CAPS, 0, 0, {18'h0, ppm_pkg::CAPS_FIXED | {cold, 6'h0, aux, 6'h0}});
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    repeat (10) @(posedge clk_in);
    for (i = 0; i < 16; i++) begin
      bus(1, CSR, 32'(i) << 9, 4'h2, 34'h0);
      bus(0, DAT, 0, 0, {26'h0, i < 8 ? vals[i*8 +: 8] : 8'h0});
      bus(0, CSR, 0, 0, csr(0, i < 8 ? scs[i*2 +: 2] : 2'h0, 4'(i), 0, 0));
    end
    bus(1, CSR, 0, 4'h2, 34'h0);
    pulse_wake();
    @(negedge clk_in);
    check({33'h0, pme}, 34'h0);
    bus(0, CSR, 0, 0, csr(1, scs[1:0], 0, 0, 0));
    bus(1, CSR, 32'h0100, 4'h2, 34'h0);
    @(negedge clk_in);
    check({33'h0, pme}, 34'h1);
    for (i = 0; i < 5; i++) begin
      bus(1, CSR, 32'(i % 4) | 32'hfc, 4'h1, 34'h0);
      bus(0, CSR, 0, 0, csr(1, scs[1:0], 0, 1, 2'(i % 4)));
      @(negedge clk_in);
      check({32'h0, pst}, 34'(i % 4));
    end
    check(34'(n_exit), 34'h1);
    cold <= 1'b1;
    pci_rst();
    bus(0, CSR, 0, 0, csr(1, 0, 0, 1, 0));
    bus(0, DAT, 0, 0, 34'h0);
    cold <= 1'b0;
    pci_rst();
    bus(0, CSR, 0, 0, csr(0, 0, 0, 0, 0));
    bus(1, CSR, 32'h0100, 4'h2, 34'h0);
    pulse_wake();
    bus(1, CSR, 32'h8100, 4'h2, 34'h0);
    @(negedge clk_in);
    check({33'h0, pme}, 34'h0);
    bus(0, CSR, 0, 0, csr(0, 0, 0, 1, 0));
    bus(1, MSK, 1, 4'h1, 34'h0);
    @(negedge clk_in);
    check({33'h0, irq}, 34'h1);
    bus(1, EVT, 1, 4'h1, 34'h0);
    bus(0, EVT, 0, 0, 34'h0);
    @(negedge clk_in);
    check({33'h0, irq}, 34'h0);
    pulse_wake();
    @(negedge clk_in);
    check({33'h0, irq}, 34'h1);
    bus(1, MSK, 0, 4'h1, 34'h0);
    @(negedge clk_in);
    check({33'h0, irq}, 34'h0);
    bus(0, 12'h200, 0, 0, {ERR, 32'h0});
    bus(1, 12'h200, 32'h1, 4'hf, {ERR, 32'h0});
    bus(1, BSE, 32'hff, 4'hf, 34'h0);
    bus(0, BSE, 0, 0, 34'h0);
    print_verdict();
  end
endmodule : ppm_power_ctrl_tb
